// [hcrs_axil_slave.sv]
`include "hcrs_params.svh"
module hcrs_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output hcrs_pkg::hcrs_addr_t wr_addr,
	output hcrs_pkg::hcrs_byte_t wr_data,
	input wire logic wr_ok,
	output logic rd_en,
	input wire logic rd_ok,
	input wire hcrs_pkg::hcrs_byte_t rd_data
);
	import hcrs_pkg::*;
	logic aw_held;
	logic w_held;
	logic lane0;
	logic [7:0] w_byte;

	// Address and data taken in either order, one write at a time
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_en = aw_held && w_held && !s_axi_bvalid && lane0;
	assign wr_data = w_byte;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_en = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			lane0 <= 1'b0;
			w_byte <= 8'h00;
			wr_addr <= 8'h00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				lane0 <= s_axi_wstrb[0];
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `HCRS_RESP_OKAY : `HCRS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_en) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_data};
				s_axi_rresp <= rd_ok ? `HCRS_RESP_OKAY : `HCRS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // hcrs_axil_slave

// [hcrs_irq_bank.sv]
`include "hcrs_params.svh"
module hcrs_irq_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire hcrs_pkg::hcrs_byte_t events,
	input wire logic clr_en,
	input wire hcrs_pkg::hcrs_byte_t clr_data,
	input wire hcrs_pkg::hcrs_byte_t mask,
	output hcrs_pkg::hcrs_byte_t status,
	output logic pending
);
	import hcrs_pkg::*;
	wire hcrs_byte_t clr_bits = clr_en ? clr_data : `HCRS_RST_ZERO;
	wire hcrs_byte_t next_status = hcrs_sticky(status, events, clr_bits);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= `HCRS_RST_ZERO;
		end else begin
			status <= next_status;
		end
	end

	// Mask bit one keeps its status bit out of pending; the event still sets status
	assign pending = |(status & ~mask);
endmodule // hcrs_irq_bank

// [hcrs_params.svh]
`ifndef HCRS_PARAMS_SVH
`define HCRS_PARAMS_SVH
// ****************************************
// Register byte offsets, B-channel bank
// ****************************************
`define HCRS_B_CFG1 8'h00
`define HCRS_B_CFG2 8'h04
`define HCRS_B_MODE 8'h08
`define HCRS_B_STATE 8'h0c
`define HCRS_B_ISTA 8'h10
`define HCRS_B_MASK 8'h14
`define HCRS_B_EXIR 8'h18
`define HCRS_B_CMD 8'h1c
`define HCRS_B_TXCH 8'h20
`define HCRS_B_RXCH 8'h24
`define HCRS_B_TXSLOT 8'h28
`define HCRS_B_RXSLOT 8'h2c
`define HCRS_B_LO 8'h00
`define HCRS_B_HI 8'h73
// ****************************************
// Register byte offsets, D-channel bank
// ****************************************
`define HCRS_D_ISTA 8'h80
`define HCRS_D_MASK 8'h84
`define HCRS_D_EXIR 8'h88
`define HCRS_D_STATE 8'h8c
`define HCRS_D_CMD 8'h90
`define HCRS_D_MODE 8'h94
`define HCRS_D_RXCL 8'h98
`define HCRS_D_RXCH 8'h9c
`define HCRS_D_SPORT 8'ha0
`define HCRS_D_CIR 8'ha4
`define HCRS_D_CIX 8'ha8
`define HCRS_D_SYNC 8'hac
`define HCRS_D_ADF 8'hb0
`define HCRS_D_LO 8'h80
`define HCRS_D_HI 8'hba
// ****************************************
// Reset values and fields
// ****************************************
`define HCRS_RST_ZERO 8'h00
`define HCRS_RST_STATE 8'h48
`define HCRS_RST_CIR 8'h7c
`define HCRS_RST_CIX 8'h3f
`define HCRS_RXCH_D_MASK 8'h1f
`define HCRS_CFG1_PWRUP_BIT 7
`define HCRS_STATE_BUSY_BIT 2
`define HCRS_RESP_OKAY 2'b00
`define HCRS_RESP_SLVERR 2'b10
`endif

// [hcrs_pkg.sv]
package hcrs_pkg;
	typedef logic [7:0] hcrs_byte_t;
	typedef logic [7:0] hcrs_addr_t;
	typedef enum logic {HCRS_IDLE, HCRS_RUN} hcrs_state_e;

	// Sticky update: a set in the clearing cycle wins
	function automatic hcrs_byte_t hcrs_sticky(input hcrs_byte_t cur, input hcrs_byte_t set,
			input hcrs_byte_t clr);
		hcrs_sticky = (cur & ~clr) | set;
	endfunction
endpackage

// [hcrs_top.sv]
// Notes on behaviour
// - Reset puts the device idle and loads every bank register's reset value.
// - B-channel registers decode inside host addresses 00h to 73h.
// - D-channel registers decode inside host addresses 80h to BAh.
// - B config one resets 00: power down, NRZ, idle ones upstream.
// - B config two resets 00: normal line use, transmit on, no frame-start irq.
// - B mode resets 00: reserved mode, one-byte address, receivers off, no loop.
// - B transmit and receive count-high reset 00: interrupt-driven, no continuous send.
// - D state resets 48: transmit pool writable, receive pool ready.
// - D receive counts reset to zero bytes; lower five high bits cleared.
// - Serial port control resets 00: upstream pin high, test loop off.
// - Command/indication receive resets 7C: channel held elsewhere, code 1111.
// - Command/indication transmit resets 3F: shared bus not requested, code 1111.
// - Synchronous-transfer control resets 00: functions off, bus address 0000.
// - D additional-feature resets 00: continuous ones as interframe fill.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "hcrs_params.svh"
module hcrs_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire hcrs_pkg::hcrs_byte_t bchan_events,
	input wire hcrs_pkg::hcrs_byte_t bchan_ext_events,
	input wire hcrs_pkg::hcrs_byte_t dchan_events,
	input wire hcrs_pkg::hcrs_byte_t dchan_ext_events,
	input wire hcrs_pkg::hcrs_byte_t bchan_status_in,
	input wire hcrs_pkg::hcrs_byte_t dchan_status_in,
	input wire hcrs_pkg::hcrs_byte_t bchan_rx_count_high_in,
	input wire hcrs_pkg::hcrs_byte_t dchan_rx_count_low_in,
	input wire hcrs_pkg::hcrs_byte_t dchan_rx_count_high_in,
	input wire hcrs_pkg::hcrs_byte_t cmd_ind_receive_in,
	input wire logic bchan_cmd_done,
	input wire logic dchan_cmd_done,
	output hcrs_pkg::hcrs_byte_t bchan_config_one,
	output hcrs_pkg::hcrs_byte_t bchan_config_two,
	output hcrs_pkg::hcrs_byte_t bchan_mode,
	output hcrs_pkg::hcrs_byte_t bchan_tx_count_high,
	output hcrs_pkg::hcrs_byte_t bchan_tx_slot_config,
	output hcrs_pkg::hcrs_byte_t bchan_rx_slot_config,
	output hcrs_pkg::hcrs_byte_t dchan_mode,
	output hcrs_pkg::hcrs_byte_t serial_port_control,
	output hcrs_pkg::hcrs_byte_t cmd_ind_transmit,
	output hcrs_pkg::hcrs_byte_t sync_transfer_control,
	output hcrs_pkg::hcrs_byte_t additional_feature,
	output hcrs_pkg::hcrs_byte_t bchan_command,
	output logic bchan_cmd_valid,
	output hcrs_pkg::hcrs_byte_t dchan_command,
	output logic dchan_cmd_valid,
	output logic device_idle,
	output logic irq
);
	import hcrs_pkg::*;

	// ****************************************
	// Bus slave
	// ****************************************
	logic wr_en;
	hcrs_addr_t wr_addr;
	hcrs_byte_t wr_data;
	logic rd_en;
	hcrs_byte_t rd_data;
	logic wr_ok;
	logic rd_ok;

	hcrs_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_ok(rd_ok),
		.rd_data(rd_data)
	);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic in_bank(input hcrs_addr_t a);
		// Decode windows of both banks
		in_bank = (a >= `HCRS_B_LO && a <= `HCRS_B_HI) || (a >= `HCRS_D_LO && a <= `HCRS_D_HI);
	endfunction

	function automatic logic is_mapped(input hcrs_addr_t a);
		is_mapped = in_bank(a) && (a[1:0] == 2'b00) && ((a <= `HCRS_B_RXSLOT) || (a >= `HCRS_D_ISTA &&
			a <= `HCRS_D_ADF));
	endfunction

	wire hcrs_addr_t rd_addr = s_axi_araddr;
	wire b_wr = wr_en && (wr_addr <= `HCRS_B_HI);
	wire d_wr = wr_en && (wr_addr >= `HCRS_D_LO) && (wr_addr <= `HCRS_D_HI);
	assign wr_ok = is_mapped(wr_addr);
	assign rd_ok = is_mapped(rd_addr);

	wire w_b_cfg1 = b_wr && wr_addr == `HCRS_B_CFG1;
	wire w_b_cfg2 = b_wr && wr_addr == `HCRS_B_CFG2;
	wire w_b_mode = b_wr && wr_addr == `HCRS_B_MODE;
	wire w_b_ista = b_wr && wr_addr == `HCRS_B_ISTA;
	wire w_b_mask = b_wr && wr_addr == `HCRS_B_MASK;
	wire w_b_cmd = b_wr && wr_addr == `HCRS_B_CMD;
	wire w_b_txch = b_wr && wr_addr == `HCRS_B_TXCH;
	wire w_b_txslot = b_wr && wr_addr == `HCRS_B_TXSLOT;
	wire w_b_rxslot = b_wr && wr_addr == `HCRS_B_RXSLOT;
	wire w_d_ista = d_wr && wr_addr == `HCRS_D_ISTA;
	wire w_d_mask = d_wr && wr_addr == `HCRS_D_MASK;
	wire w_d_cmd = d_wr && wr_addr == `HCRS_D_CMD;
	wire w_d_mode = d_wr && wr_addr == `HCRS_D_MODE;
	wire w_d_sport = d_wr && wr_addr == `HCRS_D_SPORT;
	wire w_d_cix = d_wr && wr_addr == `HCRS_D_CIX;
	wire w_d_sync = d_wr && wr_addr == `HCRS_D_SYNC;
	wire w_d_adf = d_wr && wr_addr == `HCRS_D_ADF;
	wire r_b_exir = rd_en && rd_addr == `HCRS_B_EXIR;
	wire r_d_exir = rd_en && rd_addr == `HCRS_D_EXIR;

	// ****************************************
	// Device state
	// ****************************************
	hcrs_state_e state;
	hcrs_state_e next_state;
	// Leaving power down ends the idle state
	assign next_state = bchan_config_one[`HCRS_CFG1_PWRUP_BIT] ? HCRS_RUN : HCRS_IDLE;
	assign device_idle = (state == HCRS_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= HCRS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Software-written control registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bchan_config_one <= `HCRS_RST_ZERO;
			bchan_config_two <= `HCRS_RST_ZERO;
			bchan_mode <= `HCRS_RST_ZERO;
			bchan_tx_count_high <= `HCRS_RST_ZERO;
			bchan_tx_slot_config <= `HCRS_RST_ZERO;
			bchan_rx_slot_config <= `HCRS_RST_ZERO;
			dchan_mode <= `HCRS_RST_ZERO;
			serial_port_control <= `HCRS_RST_ZERO;
			cmd_ind_transmit <= `HCRS_RST_CIX;
			sync_transfer_control <= `HCRS_RST_ZERO;
			additional_feature <= `HCRS_RST_ZERO;
		end else begin
			if (w_b_cfg1) bchan_config_one <= wr_data;
			if (w_b_cfg2) bchan_config_two <= wr_data;
			if (w_b_mode) bchan_mode <= wr_data;
			if (w_b_txch) bchan_tx_count_high <= wr_data;
			if (w_b_txslot) bchan_tx_slot_config <= wr_data;
			if (w_b_rxslot) bchan_rx_slot_config <= wr_data;
			if (w_d_mode) dchan_mode <= wr_data;
			if (w_d_sport) serial_port_control <= wr_data;
			if (w_d_cix) cmd_ind_transmit <= wr_data;
			if (w_d_sync) sync_transfer_control <= wr_data;
			if (w_d_adf) additional_feature <= wr_data;
		end
	end

	// ****************************************
	// Commands
	// ****************************************
	// A new write outranks a done pulse in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bchan_command <= `HCRS_RST_ZERO;
			dchan_command <= `HCRS_RST_ZERO;
			bchan_cmd_valid <= 1'b0;
			dchan_cmd_valid <= 1'b0;
		end else begin
			bchan_cmd_valid <= w_b_cmd;
			dchan_cmd_valid <= w_d_cmd;
			if (w_b_cmd) begin
				bchan_command <= wr_data;
			end else if (bchan_cmd_done) begin
				bchan_command <= `HCRS_RST_ZERO;
			end
			if (w_d_cmd) begin
				dchan_command <= wr_data;
			end else if (dchan_cmd_done) begin
				dchan_command <= `HCRS_RST_ZERO;
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	hcrs_byte_t bchan_irq_state;
	hcrs_byte_t dchan_irq_state;
	hcrs_byte_t bchan_irq_mask;
	hcrs_byte_t dchan_irq_mask;
	hcrs_byte_t bchan_irq_extended;
	hcrs_byte_t dchan_irq_extended;
	logic b_pending;
	logic d_pending;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bchan_irq_mask <= `HCRS_RST_ZERO;
			dchan_irq_mask <= `HCRS_RST_ZERO;
			bchan_irq_extended <= `HCRS_RST_ZERO;
			dchan_irq_extended <= `HCRS_RST_ZERO;
		end else begin
			if (w_b_mask) bchan_irq_mask <= wr_data;
			if (w_d_mask) dchan_irq_mask <= wr_data;
			// Read clears, a new event still lands
			bchan_irq_extended <= hcrs_sticky(bchan_irq_extended, bchan_ext_events,
				r_b_exir ? bchan_irq_extended : `HCRS_RST_ZERO);
			dchan_irq_extended <= hcrs_sticky(dchan_irq_extended, dchan_ext_events,
				r_d_exir ? dchan_irq_extended : `HCRS_RST_ZERO);
		end
	end

	hcrs_irq_bank u_bchan_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.events(bchan_events),
		.clr_en(w_b_ista),
		.clr_data(wr_data),
		.mask(bchan_irq_mask),
		.status(bchan_irq_state),
		.pending(b_pending)
	);

	hcrs_irq_bank u_dchan_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.events(dchan_events),
		.clr_en(w_d_ista),
		.clr_data(wr_data),
		.mask(dchan_irq_mask),
		.status(dchan_irq_state),
		.pending(d_pending)
	);

	// Power down forwards no interrupt
	assign irq = (b_pending || d_pending) && (state == HCRS_RUN);

	// ****************************************
	// Status captured from the datapath
	// ****************************************
	hcrs_byte_t bchan_state;
	hcrs_byte_t dchan_state;
	hcrs_byte_t bchan_rx_count_high;
	hcrs_byte_t dchan_rx_count_low;
	hcrs_byte_t dchan_rx_count_high;
	hcrs_byte_t cmd_ind_receive;
	hcrs_byte_t next_bchan_state;
	hcrs_byte_t next_dchan_state;

	// Idle shows the fixed ready pattern; busy follows the command
	assign next_bchan_state = (next_state == HCRS_IDLE) ? `HCRS_RST_STATE :
		(bchan_status_in | {5'h00, |bchan_command, 2'b00});
	assign next_dchan_state = (next_state == HCRS_IDLE) ? `HCRS_RST_STATE :
		(dchan_status_in | {5'h00, |dchan_command, 2'b00});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bchan_state <= `HCRS_RST_STATE;
			dchan_state <= `HCRS_RST_STATE;
			bchan_rx_count_high <= `HCRS_RST_ZERO;
			dchan_rx_count_low <= `HCRS_RST_ZERO;
			dchan_rx_count_high <= `HCRS_RST_ZERO;
			cmd_ind_receive <= `HCRS_RST_CIR;
		end else begin
			bchan_state <= next_bchan_state;
			dchan_state <= next_dchan_state;
			bchan_rx_count_high <= bchan_rx_count_high_in;
			dchan_rx_count_low <= dchan_rx_count_low_in;
			dchan_rx_count_high <= dchan_rx_count_high_in;
			cmd_ind_receive <= cmd_ind_receive_in;
		end
	end

	// ****************************************
	// Read data select
	// ****************************************
	// Write-only registers read as zero
	always_comb begin
		case (rd_addr)
			`HCRS_B_CFG1: rd_data = bchan_config_one;
			`HCRS_B_CFG2: rd_data = bchan_config_two;
			`HCRS_B_MODE: rd_data = bchan_mode;
			`HCRS_B_STATE: rd_data = bchan_state;
			`HCRS_B_ISTA: rd_data = bchan_irq_state;
			`HCRS_B_EXIR: rd_data = bchan_irq_extended;
			`HCRS_B_RXCH: rd_data = bchan_rx_count_high;
			`HCRS_B_TXSLOT: rd_data = bchan_tx_slot_config;
			`HCRS_B_RXSLOT: rd_data = bchan_rx_slot_config;
			`HCRS_D_ISTA: rd_data = dchan_irq_state;
			`HCRS_D_EXIR: rd_data = dchan_irq_extended;
			`HCRS_D_STATE: rd_data = dchan_state;
			`HCRS_D_MODE: rd_data = dchan_mode;
			`HCRS_D_RXCL: rd_data = dchan_rx_count_low;
			`HCRS_D_RXCH: rd_data = dchan_rx_count_high;
			`HCRS_D_SPORT: rd_data = serial_port_control;
			`HCRS_D_CIR: rd_data = cmd_ind_receive;
			`HCRS_D_SYNC: rd_data = sync_transfer_control;
			`HCRS_D_ADF: rd_data = additional_feature;
			default: rd_data = `HCRS_RST_ZERO;
		endcase
	end
endmodule // hcrs_top

// [hcrs_top_asserts.sv]
`include "hcrs_params.svh"
module hcrs_top_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire hcrs_pkg::hcrs_byte_t bchan_config_one,
	input wire hcrs_pkg::hcrs_byte_t serial_port_control,
	input wire hcrs_pkg::hcrs_byte_t cmd_ind_transmit,
	input wire logic device_idle,
	input wire logic irq
);
	import hcrs_pkg::*;
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****
	// Address classes
	// ****
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic ar_al = s_axi_araddr[1:0] == 2'b00;
	wire logic ar_hole = ar_al && ((s_axi_araddr >= 8'h30 && s_axi_araddr <= 8'h70) || s_axi_araddr == 8'hb4);
	wire logic ar_known = ar_al && (s_axi_araddr <= 8'h2c || (s_axi_araddr >= 8'h80 && s_axi_araddr <= 8'hb0));
	// ****
	// Properties
	// ****
	rst_values_a: assert property ($rose(aresetn) |-> bchan_config_one == 8'h00 &&
		serial_port_control == 8'h00 && cmd_ind_transmit == 8'h3f && device_idle && !irq)
		else $error("reset values wrong after release");
	read_lat_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	read_hole_a: assert property (ar_take && ar_hole |=> s_axi_rresp == `HCRS_RESP_SLVERR)
		else $error("hole read not refused");
	read_known_a: assert property (ar_take && ar_known |=> s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h0)
		else $error("mapped read refused or upper bits set");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	idle_quiet_a: assert property (device_idle |-> !irq)
		else $error("interrupt while idle");
	wr_cov: cover property (s_axi_bvalid && s_axi_bready);
	hole_cov: cover property (ar_take && ar_hole);
	irq_cov: cover property ($rose(irq));
	run_cov: cover property ($fell(device_idle));
endmodule // hcrs_top_asserts

bind hcrs_top hcrs_top_asserts u_hcrs_top_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bchan_config_one,
	.serial_port_control, .cmd_ind_transmit, .device_idle, .irq);

// [hcrs_top_test.sv]
module hcrs_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import hcrs_pkg::*;
	localparam logic [1:0] ok = 2'b00;
	localparam logic [1:0] er = 2'b10;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, strb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bchan_cmd_done, dchan_cmd_done;
	hcrs_byte_t bchan_events, bchan_ext_events, dchan_events, dchan_ext_events, bchan_status_in;
	hcrs_byte_t dchan_status_in, bchan_rx_count_high_in, dchan_rx_count_low_in, dchan_rx_count_high_in;
	hcrs_byte_t cmd_ind_receive_in, bchan_config_one, bchan_config_two, bchan_mode, bchan_tx_count_high;
	hcrs_byte_t bchan_tx_slot_config, bchan_rx_slot_config, dchan_mode, serial_port_control, ev, v;
	hcrs_byte_t cmd_ind_transmit, sync_transfer_control, additional_feature, bchan_command, dchan_command;
	logic bchan_cmd_valid, dchan_cmd_valid, device_idle, irq;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [7:0] mdl [256];
	logic [7:0] rwq [$] = '{8'h04, 8'h08, 8'h28, 8'h2c, 8'h94, 8'ha0, 8'hac, 8'hb0};
	logic [7:0] holes [$] = '{8'h30, 8'h70, 8'hb4, 8'h01, 8'h81};
	logic [7:0] ra [25] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
		8'h2c, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0};
	logic [7:0] rv [25] = '{0, 0, 0, 8'h48, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'h48, 0, 0, 0, 0, 0, 8'h7c, 0, 0, 0};
	hcrs_top u_hcrs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bchan_events,
		.bchan_ext_events, .dchan_events, .dchan_ext_events, .bchan_status_in, .dchan_status_in,
		.bchan_rx_count_high_in, .dchan_rx_count_low_in, .dchan_rx_count_high_in, .cmd_ind_receive_in,
		.bchan_cmd_done, .dchan_cmd_done, .bchan_config_one, .bchan_config_two, .bchan_mode, .bchan_tx_count_high,
		.bchan_tx_slot_config, .bchan_rx_slot_config, .dchan_mode, .serial_port_control, .cmd_ind_transmit,
		.sync_transfer_control, .additional_feature, .bchan_command, .bchan_cmd_valid, .dchan_command,
		.dchan_cmd_valid, .device_idle, .irq);
	// ****
	// Bus tasks and checks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk($sformatf("bresp %h", a), {30'h0, e}, {30'h0, s_axi_bresp} | {31'h0, ~s_axi_bvalid});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] x);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk($sformatf("rresp %h", a), {30'h0, x}, {30'h0, s_axi_rresp} | {31'h0, ~s_axi_rvalid});
		if (x == ok) chk($sformatf("rdata %h", a), e, s_axi_rdata);
	endtask
	task automatic reset_check();
		for (int i = 0; i < 25; i++) begin
			if (i < 12) rchk(ra[i], {24'h0, rv[i]}, ok);
			else rchk(ra[i], {24'h0, rv[i]}, ok);
		end
		chk("b ports", 0, {bchan_config_one, bchan_config_two, bchan_mode, bchan_tx_count_high});
		chk("d ports", 0, {dchan_mode, serial_port_control, sync_transfer_control, additional_feature});
		chk("cix", 32'h3f, {24'h0, cmd_ind_transmit});
		chk("idle irq", 2, {device_idle, irq});
		$display("test reset values done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Whole run needs about 370 cycles
	initial begin
		#60000;
		n_mismatch++;
		complete_run();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		aresetn = 1'b0;
		strb = 4'hf;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, bchan_cmd_done, dchan_cmd_done} = '0;
		{bchan_events, bchan_ext_events, dchan_events, dchan_ext_events, bchan_status_in} = '0;
		{dchan_status_in, bchan_rx_count_high_in, dchan_rx_count_low_in, dchan_rx_count_high_in} = '0;
		cmd_ind_receive_in = 8'h7c;
		void'($urandom(32'h68b6e6bc));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		foreach (rwq[i]) begin
			mdl[rwq[i]] = 8'($urandom);
			wr(rwq[i], {24'h0, mdl[rwq[i]]}, ok);
		end
		strb = 4'he;
		// Lane zero disabled: no write
		wr(rwq[0], 32'h0, ok);
		strb = 4'hf;
		foreach (holes[i]) wr(holes[i], $urandom, er);
		foreach (holes[i]) rchk(holes[i], 0, er);
		foreach (rwq[i]) rchk(rwq[i], {24'h0, mdl[rwq[i]]}, ok);
		rchk(8'h00, 0, ok);
		chk("b rw", {mdl[8'h04], mdl[8'h08], mdl[8'h28], mdl[8'h2c]},
			{bchan_config_two, bchan_mode, bchan_tx_slot_config, bchan_rx_slot_config});
		chk("d rw", {mdl[8'h94], mdl[8'ha0], mdl[8'hac], mdl[8'hb0]},
			{dchan_mode, serial_port_control, sync_transfer_control, additional_feature});
		v = 8'($urandom);
		wr(8'h20, {24'h0, v}, ok);
		wr(8'ha8, {24'h0, ~v}, ok);
		chk("wo ports", {16'h0, v, ~v}, {16'h0, bchan_tx_count_high, cmd_ind_transmit});
		rchk(8'h20, 0, ok);
		$display("test access done");
		wr(8'h00, 32'h80, ok);
		@(posedge aclk);
		chk("run", 32'h80, {24'h0, bchan_config_one} | {31'h0, device_idle});
		for (int b = 0; b < 2; b++) begin
			ev = 8'h01 << $urandom_range(7, 0);
			v = b ? 8'h80 : 8'h10;
			@(posedge aclk);
			if (b) {dchan_events, dchan_ext_events} <= {ev, ev};
			else {bchan_events, bchan_ext_events} <= {ev, ev};
			@(posedge aclk);
			{bchan_events, bchan_ext_events, dchan_events, dchan_ext_events} <= '0;
			@(posedge aclk);
			chk("irq set", 1, irq);
			rchk(v, {24'h0, ev}, ok);
			wr(v + 8'h04, {24'h0, ev}, ok);
			chk("irq masked", 0, irq);
			rchk(v + 8'h04, 0, ok);
			wr(v + 8'h04, 0, ok);
			chk("irq unmasked", 1, irq);
			wr(v, {24'h0, ev}, ok);
			chk("irq clear", 0, irq);
			rchk(v, 0, ok);
			rchk(v + 8'h08, {24'h0, ev}, ok);
			rchk(v + 8'h08, 0, ok);
		end
		$display("test interrupts done");
		for (int b = 0; b < 2; b++) begin
			ev = 8'($urandom) & 8'hfb;
			v = 8'($urandom) | 8'h01;
			bchan_status_in <= ev;
			dchan_status_in <= ev;
			wr(b ? 8'h90 : 8'h1c, {24'h0, v}, ok);
			chk("cmd", {23'h0, 1'b1, v}, {23'h0, b ? dchan_cmd_valid : bchan_cmd_valid, b ? dchan_command : bchan_command});
			rchk(b ? 8'h90 : 8'h1c, 0, ok);
			rchk(b ? 8'h8c : 8'h0c, {24'h0, ev | 8'h04}, ok);
			if (b) dchan_cmd_done <= 1'b1;
			else bchan_cmd_done <= 1'b1;
			@(posedge aclk);
			{bchan_cmd_done, dchan_cmd_done} <= '0;
			@(posedge aclk);
			chk("cmd done", 0, {24'h0, b ? dchan_command : bchan_command});
			rchk(b ? 8'h8c : 8'h0c, {24'h0, ev}, ok);
		end
		v = 8'($urandom);
		{bchan_rx_count_high_in, dchan_rx_count_low_in, dchan_rx_count_high_in, cmd_ind_receive_in} <= {v, ~v, v & 8'h1f, ~v};
		rchk(8'h24, {24'h0, v}, ok);
		rchk(8'h98, {24'h0, ~v}, ok);
		rchk(8'h9c, {24'h0, v & 8'h1f}, ok);
		rchk(8'ha4, {24'h0, ~v}, ok);
		$display("test commands done");
		{bchan_status_in, dchan_status_in, bchan_rx_count_high_in, dchan_rx_count_low_in} <= '0;
		{dchan_rx_count_high_in, cmd_ind_receive_in} <= {8'h00, 8'h7c};
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		reset_check();
		complete_run();
	end
endmodule // hcrs_top_test
